// ### tb/adc_chain_partner.sv
// Purpose: downstream converter feeding the daisy input
// Assumes: the host gives the extra clock before the relayed frame
// Notes: line toggles on each clock before its pattern starts, and once on deselect, so stale values never match
`timescale 1ns/1ns
module adc_chain_partner (
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic [7:0] lead_i,
    input wire logic [31:0] pattern_i,
    output logic daisy_o
);
    int rises = 0;
    initial daisy_o = 1'b0;
    // link wired direct, no retiming flop needed at this speed
    // conversions are started outside this model
    always @(posedge sclk_i or posedge cs_b_i) begin
        if (cs_b_i) begin
            rises <= 0;
            daisy_o <= ~daisy_o;
        end else begin
            rises <= rises + 1;
            daisy_o <= (rises + 1 >= lead_i) ? pattern_i[(rises + 1 - lead_i) % 32] : ~daisy_o;
        end
    end
endmodule : adc_chain_partner

// ### tb/adc_daisy_props.sv
// Purpose: port checker for the daisy-chain readout block
// Assumes: config inputs change only while deselected
// Notes: counts sampled serial clock rises per selection
`timescale 1ns/1ns
module adc_daisy_props
    import adc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic daisy_enable_i,
    input wire logic [RATE_SEL_W-1:0] rate_select_field_i,
    input wire logic dout_o,
    input wire logic dout_oe_o,
    input wire logic frame_end_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    logic sclk_q;
    int rises_reg;
    int rises_next;
    int nbits;
    always_comb begin
        nbits = (rate_select_field_i <= RATE_NARROW_MAX) ? STATUS_BITS + NUM_CHANNELS * RES_NARROW
            : STATUS_BITS + NUM_CHANNELS * RES_WIDE;
        rises_next = rises_reg;
        if (cs_b_i) rises_next = 0;
        else if (sclk_i && !sclk_q) rises_next = rises_reg + 1;
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rises_reg <= 0;
            sclk_q <= 1'b0;
        end else begin
            rises_reg <= rises_next;
            sclk_q <= sclk_i;
        end
    end
    oe_idle_a: assert property (cs_b_i [*6] |-> !dout_oe_o && !dout_o)
        else $error("output active while deselected");
    oe_rise_a: assert property ($fell(cs_b_i) |-> ##[3:5] dout_oe_o)
        else $error("output not enabled after select");
    end_count_a: assert property (frame_end_o |-> rises_reg == nbits)
        else $error("frame end at wrong bit count");
    end_timely_a: assert property ($rose(sclk_i) && !cs_b_i && rises_reg == nbits - 1
        |-> ##[3:5] frame_end_o) else $error("frame end missing");
    end_pulse_a: assert property (frame_end_o |=> !frame_end_o)
        else $error("frame end longer than one cycle");
    relay_off_a: assert property (!cs_b_i && !daisy_enable_i && $past(rises_reg, 6) > nbits
        |-> !dout_o) else $error("relay active while disabled");
endmodule : adc_daisy_props
bind adc_daisy_top adc_daisy_props props_u (.clk_i, .rst_b_i, .sclk_i, .cs_b_i, .daisy_enable_i,
    .rate_select_field_i, .dout_o, .dout_oe_o, .frame_end_o);

// ### tb/test_adc_daisy_chain_readout.sv
// Purpose: self-checking bench for the daisy-chain readout block
// Assumes: serial clock high and low phases of four system clocks
// Notes: expected bits rebuilt from the latched words and partner pattern
`timescale 1ns/1ns
module test_adc_daisy_chain_readout;
    import adc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic sclk_i = 1'b0;
    logic cs_b_i = 1'b1;
    logic daisy_in_i;
    logic daisy_enable_i = 1'b0;
    logic [RATE_SEL_W-1:0] rate_select_field_i = '0;
    logic [STATUS_BITS-1:0] status_word_i = '0;
    logic [SAMPLE_BUS_W-1:0] sample_bus_i = '0;
    logic dout_o;
    logic dout_oe_o;
    logic frame_end_o;
    logic [7:0] lead = 8'hFF;
    logic [31:0] pattern = '0;
    logic [31:0] xs_state = 32'h000109A4;
    logic [31:0] r;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    adc_daisy_top dut_u (.clk_i, .rst_b_i, .sclk_i, .cs_b_i, .daisy_in_i, .daisy_enable_i,
        .rate_select_field_i, .status_word_i, .sample_bus_i, .dout_o, .dout_oe_o, .frame_end_o);
    adc_chain_partner partner_u (.sclk_i, .cs_b_i, .lead_i(lead), .pattern_i(pattern),
        .daisy_o(daisy_in_i));
    // one external master clock for the readout block only; the partner runs on sclk
    initial forever #50 clk_i = ~clk_i;
    function automatic logic [31:0] xs();
        xs_state = xs_state ^ (xs_state << 13);
        xs_state = xs_state ^ (xs_state >> 17);
        xs_state = xs_state ^ (xs_state << 5);
        return xs_state;
    endfunction : xs
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic check_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask : check_bit
    task automatic run_frame(input logic en, input logic [RATE_SEL_W-1:0] rate);
        int w;
        int n;
        int i;
        int j;
        w = (rate <= RATE_NARROW_MAX) ? RES_NARROW : RES_WIDE;
        n = STATUS_BITS + NUM_CHANNELS * w;
        daisy_enable_i = en;
        rate_select_field_i = rate;
        status_word_i = 24'(xs());
        for (i = 0; i < 6; i++) sample_bus_i[i*32 +: 32] = xs();
        pattern = xs();
        lead = 8'(n + 1);
        tick(4);
        cs_b_i = 1'b0;
        tick(6);
        check_bit(dout_oe_o, 1'b1, "enable on select");
        // host clocks only own frame plus a short relayed stretch
        for (i = 1; i <= n + 24; i++) begin
            sclk_i = 1'b1;
            tick(4);
            sclk_i = 1'b0;
            tick(2);
            j = i - 1 - STATUS_BITS;
            // status words trusted from the first device only
            if (i <= STATUS_BITS) check_bit(dout_o, status_word_i[STATUS_BITS-i], "status");
            else if (i <= n) check_bit(dout_o, sample_bus_i[(j/w)*RES_WIDE+w-1-j%w], "data");
            else if (!en) check_bit(dout_o, 1'b0, "relay off");
            else if (i > n + 1) check_bit(dout_o, pattern[(i-n-2)%32], "relay");
            tick(2);
        end
        cs_b_i = 1'b1;
        tick(6);
        check_bit(dout_oe_o, 1'b0, "enable off");
        check_bit(dout_o, 1'b0, "idle output");
    endtask : run_frame
    initial begin
        tick(4);
        rst_b_i = 1'b1;
        tick(8);
        run_frame(1'b1, 3'h1);
        run_frame(1'b0, 3'h2);
        for (int c = 0; c < 8; c++) begin
            r = xs();
            run_frame(r[0], 3'(c));
        end
        give_verdict();
    end
endmodule : test_adc_daisy_chain_readout

// ### verilog/adc_daisy_top.sv
// Purpose: serial data output of one converter with daisy-chain relay
// Assumes: serial clock idle low, data changes on rising edge, read on falling edge
// Notes: serial pins are sampled by clk_i; sclk must stay well below clk_i / 4
`timescale 1ns/1ns
module adc_daisy_top
    import adc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic sclk_i,
    input wire logic cs_b_i,
    input wire logic daisy_in_i,
    input wire logic daisy_enable_i,
    input wire logic [RATE_SEL_W-1:0] rate_select_field_i,
    input wire logic [STATUS_BITS-1:0] status_word_i,
    input wire logic [SAMPLE_BUS_W-1:0] sample_bus_i,
    output logic dout_o,
    output logic dout_oe_o,
    output logic frame_end_o
);

    // reset release through two flops
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_b;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_b = rst_sync_reg;

    // serial pins into the clk_i domain
    logic [2:0] pin_sync;
    logic sclk_s;
    logic cs_b_s;
    logic daisy_s;

    adc_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b),
        .d_i({sclk_i, ~cs_b_i, daisy_in_i}),
        .q_o(pin_sync)
    );

    assign sclk_s = pin_sync[2];
    // select travels inverted so the synchroniser's reset value reads as deselected
    assign cs_b_s = ~pin_sync[1];
    assign daisy_s = pin_sync[0];

    // edge detection on synchronised copies
    logic sclk_prev_reg;
    logic cs_b_prev_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            sclk_prev_reg <= 1'b0;
            cs_b_prev_reg <= 1'b1;
        end else begin
            sclk_prev_reg <= sclk_s;
            cs_b_prev_reg <= cs_b_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_prev_reg;
    assign sclk_fall = ~sclk_s & sclk_prev_reg;
    assign cs_fall = cs_b_prev_reg & ~cs_b_s;
    assign cs_rise = ~cs_b_prev_reg & cs_b_s;

    // sample width from the rate select field
    function automatic logic is_wide(input logic [RATE_SEL_W-1:0] rate);
        is_wide = (rate > RATE_NARROW_MAX);
    endfunction : is_wide

    // frame length in bits for a given sample width
    function automatic logic [CNT_W-1:0] frame_bits(input logic wide);
        frame_bits = wide ? FRAME_BITS_WIDE : FRAME_BITS_NARROW;
    endfunction : frame_bits

    // status then channel 0 upward, left-aligned, msb first
    function automatic logic [FRAME_MAX-1:0] pack_frame(
        input logic [STATUS_BITS-1:0] st,
        input logic [SAMPLE_BUS_W-1:0] smp,
        input logic wide
    );
        logic [FRAME_MAX-1:0] f;
        f = '0;
        f[FRAME_MAX-1 -: STATUS_BITS] = st;
        for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
            if (wide) begin
                f[FRAME_MAX-1-STATUS_BITS-ch*RES_WIDE -: RES_WIDE] = smp[ch*RES_WIDE +: RES_WIDE];
            end else begin
                f[FRAME_MAX-1-STATUS_BITS-ch*RES_NARROW -: RES_NARROW] =
                    smp[ch*RES_WIDE +: RES_NARROW];
            end
        end
        pack_frame = f;
    endfunction : pack_frame

    // shifter state
    adc_state_e state_reg;
    adc_state_e state_next;
    logic [FRAME_MAX-1:0] shift_reg;
    logic [FRAME_MAX-1:0] shift_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] len_reg;
    logic [CNT_W-1:0] len_next;
    logic daisy_on_reg;
    logic daisy_on_next;
    logic capture_reg;
    logic capture_next;
    logic dout_reg;
    logic dout_next;
    logic oe_reg;
    logic oe_next;
    logic end_reg;
    logic end_next;

    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        len_next = len_reg;
        daisy_on_next = daisy_on_reg;
        capture_next = capture_reg;
        dout_next = dout_reg;
        oe_next = oe_reg;
        end_next = 1'b0;
        case (state_reg)
            ADC_ST_IDLE: begin
                // shared select
                // every device reacts to the common select whatever its chain position
                if (cs_fall) begin
                    state_next = ADC_ST_SHIFT;
                    shift_next = pack_frame(status_word_i, sample_bus_i,
                                            is_wide(rate_select_field_i));
                    len_next = frame_bits(is_wide(rate_select_field_i));
                    daisy_on_next = daisy_enable_i;
                    cnt_next = '0;
                    capture_next = 1'b0;
                    dout_next = DOUT_RESET;
                    oe_next = 1'b1;
                end
            end
            ADC_ST_SHIFT: begin
                if (cs_rise) begin
                    state_next = ADC_ST_IDLE;
                    oe_next = 1'b0;
                    dout_next = DOUT_RESET;
                end else begin
                    if (sclk_fall) begin
                        capture_next = daisy_s;
                    end
                    if (sclk_rise) begin
                        shift_next = {shift_reg[FRAME_MAX-2:0], 1'b0};
                        if (cnt_reg < len_reg) begin
                            dout_next = shift_reg[FRAME_MAX-1];
                        end else begin
                            // one clock delay
                            // first relayed bit was sampled before the extra clock: don't-care
                            dout_next = daisy_on_reg ? capture_reg : 1'b0;
                        end
                        if (cnt_reg != CNT_SAT) begin
                            cnt_next = cnt_reg + CNT_W'(1);
                        end
                        if (cnt_reg + CNT_W'(1) == len_reg) begin
                            end_next = 1'b1;
                        end
                    end
                end
            end
            default: begin
                state_next = ADC_ST_IDLE;
                oe_next = 1'b0;
                dout_next = DOUT_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ADC_ST_IDLE;
            shift_reg <= '0;
            cnt_reg <= '0;
            len_reg <= FRAME_BITS_WIDE;
            daisy_on_reg <= 1'b0;
            capture_reg <= 1'b0;
            dout_reg <= DOUT_RESET;
            oe_reg <= 1'b0;
            end_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            len_reg <= len_next;
            daisy_on_reg <= daisy_on_next;
            capture_reg <= capture_next;
            dout_reg <= dout_next;
            oe_reg <= oe_next;
            end_reg <= end_next;
        end
    end

    assign dout_o = dout_reg;
    assign dout_oe_o = oe_reg;
    assign frame_end_o = end_reg;

endmodule : adc_daisy_top

// ### verilog/adc_pkg.sv
// Purpose: shared constants for the daisy-chain serial readout block
// Assumes: eight channels, 24-bit status word, 16- or 24-bit samples
// Notes: frame lengths are derived here once and reused by the top module
package adc_pkg;

    // frame layout
    localparam int STATUS_BITS = 24;
    localparam int NUM_CHANNELS = 8;
    localparam int RES_NARROW = 16;
    localparam int RES_WIDE = 24;
    localparam int FRAME_MAX = STATUS_BITS + NUM_CHANNELS * RES_WIDE;
    localparam int SAMPLE_BUS_W = NUM_CHANNELS * RES_WIDE;

    // frame lengths as counter values
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] FRAME_BITS_WIDE = CNT_W'(STATUS_BITS + NUM_CHANNELS * RES_WIDE);
    localparam logic [CNT_W-1:0] FRAME_BITS_NARROW =
        CNT_W'(STATUS_BITS + NUM_CHANNELS * RES_NARROW);
    localparam logic [CNT_W-1:0] CNT_SAT = 8'hFF;

    // rate select field: codes up to this value give 16-bit samples
    localparam int RATE_SEL_W = 3;
    localparam logic [RATE_SEL_W-1:0] RATE_NARROW_MAX = 3'h1;

    // clocking figures
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCLK_MIN_PERIOD_NS = 800;
    localparam int SCLK_MIN_CYCLES = SCLK_MIN_PERIOD_NS / CLK_PERIOD_NS;

    // reset values
    localparam logic DOUT_RESET = 1'b0;

    typedef enum logic [0:0] {
        ADC_ST_IDLE = 1'b0,
        ADC_ST_SHIFT = 1'b1
    } adc_state_e;

endpackage : adc_pkg

// ### verilog/adc_sync.sv
// Purpose: two-flop synchroniser for asynchronous level inputs
// Assumes: destination clock much faster than the input's toggle rate
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ns
module adc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    if (WIDTH < 1) begin : g_width_check
        $error("adc_sync: WIDTH must be at least 1");
    end

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_reg;
            logic sync_reg;
            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                end else begin
                    meta_reg <= d_i[gi];
                    sync_reg <= meta_reg;
                end
            end
            assign q_o[gi] = sync_reg;
        end
    endgenerate

endmodule : adc_sync
